// ===== hdl/cte_bit_timer.sv
`timescale 1ns/10ps
module cte_bit_timer
  import cte_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_tq_tick,
  input wire logic [3:0] i_seg1_code,
  input wire logic [2:0] i_seg2_code,
  output logic o_sample_pt,
  output logic o_bit_end,
  output logic o_timing_bad
);

  // ***************************************************************
  // Quantum counter across one bit time
  // ***************************************************************
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] seg1_tq;
  logic [4:0] seg2_tq;
  logic [4:0] last_tq;
  logic valid;

  // Length is code plus one; a zero code stalls the timer
  assign seg1_tq = {1'b0, i_seg1_code} + TQ_ONE; // RL2
  assign seg2_tq = {2'b00, i_seg2_code} + TQ_ONE; // RL1
  assign valid = (i_seg1_code != 4'h0) && (i_seg2_code != 3'h0);
  assign last_tq = seg1_tq + seg2_tq;
  assign cnt_d = !valid ? TQ_ZERO :
                 !i_tq_tick ? cnt_q :
                 (cnt_q == last_tq) ? TQ_ZERO : cnt_q + TQ_ONE;

  // Quantum 0 is sync; sample closes the last segment-one quantum
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_q <= TQ_ZERO;
      o_sample_pt <= 1'b0;
      o_bit_end <= 1'b0;
      o_timing_bad <= 1'b1;
    end
    else if (i_ce)
    begin
      cnt_q <= cnt_d;
      o_sample_pt <= valid && i_tq_tick && (cnt_q == seg1_tq); // RL19
      o_bit_end <= valid && i_tq_tick && (cnt_q == last_tq);
      o_timing_bad <= !valid;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_seg1_close;
    i_ce && valid && i_tq_tick && (cnt_q == seg1_tq);
  endsequence

  a_sample_spot: assert property (s_seg1_close |=> o_sample_pt) // RL19
    else $error("sample strobe missed at end of segment one");
  a_sample_only: assert property ( // RL19
    $rose(o_sample_pt) |-> $past(cnt_q) == $past(seg1_tq))
    else $error("sample strobe away from segment boundary");

endmodule

// ===== hdl/cte_err_core.sv
`timescale 1ns/10ps
// What this block does
// RL1: Phase segment two code n gives n+1 quanta; code zero is invalid.
// RL2: Segment one code n gives n+1 quanta; code zero is invalid.
// RL3: Software keeps segment one no shorter than phase segment two.
// RL4: Software programs at least eight quanta per bit.
// RL5: Software should place the sample point at 75% or later.
// RL6: Transmit fault counter is readable, resets to zero, host writable.
// RL7: Receive fault counter is readable, resets to zero, host writable.
// RL8: Warning flag set while a counter lies between 96 and 127.
// RL9: Transmit count 128 to 255 sets transmit passive and passive flag.
// RL10: Receive count 128 to 255 sets receive passive and passive flag.
// RL11: Transmit count passing 255 enters line off and sets its flags.
// RL12: With auto recovery, 128 x 11 recessive bits end line off.
// RL13: Without auto recovery, the host drives recovery from line off.
// RL14: Match field reads zero, or eight plus the matching filter index.
// RL15: Lowest numbered matching filter is reported.
// RL16: Last tag bits hold the tag of the last good transmission.
// RL17: Transmitter state reads off, idle, waiting or sending.
// RL18: Timing register writes land only in initialization mode.
// RL19: Bit sample is taken at the end of segment one.
// RL20: Line off indication clears itself after a recovery sequence.
// RL21: Counters follow standard fault confinement; flags track counters.
// RL22: Recovery zeroes both counters and clears passive and warning.
module cte_err_core
  import cte_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_op,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_init_mode,
  input wire logic i_auto_recover_en,
  input wire logic i_host_recover,
  input wire logic i_tq_tick,
  input wire logic i_rx_bit,
  input wire logic i_tx_err,
  input wire logic i_tx_ok,
  input wire logic i_rx_err,
  input wire logic i_rx_err_major,
  input wire logic i_rx_ok,
  input wire logic i_rx_valid,
  input wire logic [cte_pkg::NUM_FILTERS-1:0] i_filter_hits,
  input wire logic i_tx_done,
  input wire logic [1:0] i_tx_tag,
  input wire logic i_tx_allow,
  input wire logic i_queue_empty,
  input wire logic i_tx_busy,
  output logic [7:0] o_reg_rdata,
  output logic o_warn_flag,
  output logic o_passive_flag,
  output logic o_line_off_flag,
  output logic o_tx_passive_bit,
  output logic o_rx_passive_bit,
  output logic o_sample_pt,
  output logic o_bit_end,
  output logic o_timing_bad,
  output logic [3:0] o_match_index,
  output logic [1:0] o_last_tag_bits,
  output cte_pkg::cte_txst_e o_tx_state
);

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [7:0] timing_q;
  logic [7:0] tx_fault_count_q;
  logic [7:0] rx_fault_count_q;
  logic [10:0] run_q;
  logic [7:0] tx_cnt_d;
  logic [7:0] rx_cnt_d;
  logic [10:0] run_d;
  logic off_d;
  cte_txst_e txst_d;
  logic [3:0] pick_code;

  // ***************************************************************
  // Op-code decode
  // ***************************************************************
  wire wr_timing = i_reg_wr && (i_reg_op == OP_WR_TIMING);
  wire wr_tx_cnt = i_reg_wr && (i_reg_op == OP_WR_TXCNT);
  wire wr_rx_cnt = i_reg_wr && (i_reg_op == OP_WR_RXCNT);
  // Timing changes are locked out once the node has left init
  wire timing_take = wr_timing && i_init_mode; // RL18

  // Read mux; ERR low bits belong to the frame checker elsewhere
  wire [7:0] msg_status = {o_match_index, o_last_tag_bits, o_tx_state};
  wire [7:0] err_view = {o_line_off_flag, o_tx_passive_bit,
                         o_rx_passive_bit, ERR_LOW_ZERO};
  wire [7:0] rd_d = (i_reg_op == OP_RD_TIMING) ? timing_q :
                    (i_reg_op == OP_RD_TXCNT) ? tx_fault_count_q :
                    (i_reg_op == OP_RD_RXCNT) ? rx_fault_count_q :
                    (i_reg_op == OP_RD_MSG) ? msg_status :
                    (i_reg_op == OP_RD_ERR) ? err_view : RD_NONE;

  // ***************************************************************
  // Bit timing and recovery watch
  // ***************************************************************
  cte_bit_timer u_timer (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_tq_tick(i_tq_tick),
    .i_seg1_code(timing_q[TM_SEG1_HI:TM_SEG1_LO]),
    .i_seg2_code(timing_q[TM_SEG2_HI:TM_SEG2_LO]),
    .o_sample_pt(o_sample_pt),
    .o_bit_end(o_bit_end),
    .o_timing_bad(o_timing_bad)
  );

  // Recessive run counts sampled bits; a dominant bit restarts it
  wire run_full = (run_q == RECOV_LAST);
  wire auto_done = o_line_off_flag && i_auto_recover_en && o_sample_pt &&
                   i_rx_bit && run_full; // RL12
  // Host path is the only way out when auto recovery is off
  wire host_done = o_line_off_flag && i_host_recover; // RL13
  wire recover_go = auto_done || host_done;
  assign run_d = (!o_line_off_flag || recover_go) ? RUN_ZERO :
                 !o_sample_pt ? run_q :
                 i_rx_bit ? run_q + RUN_ONE : RUN_ZERO;

  // ***************************************************************
  // Fault confinement counters
  // ***************************************************************
  wire [8:0] tx_sum = {1'b0, tx_fault_count_q} + TX_ERR_INC;
  wire [8:0] rx_sum = {1'b0, rx_fault_count_q} +
                      (i_rx_err_major ? RX_MAJOR_INC : RX_ERR_INC);
  wire tx_over = i_tx_err && tx_sum[8] && !o_line_off_flag; // RL11
  wire tx_nz = (tx_fault_count_q != CNT_RESET);
  wire rx_nz = (rx_fault_count_q != CNT_RESET);
  wire rx_hi = (rx_fault_count_q >= PASSIVE_LO);

  // Recovery beats host writes; a host write beats bus events so
  // that test values land exactly; counters freeze while line off
  assign tx_cnt_d = recover_go ? CNT_RESET : // RL22
                    wr_tx_cnt ? i_reg_wdata : // RL6
                    o_line_off_flag ? tx_fault_count_q :
                    tx_over ? CNT_MAX :
                    i_tx_err ? tx_sum[7:0] : // RL21
                    (i_tx_ok && tx_nz) ? tx_fault_count_q - CNT_ONE :
                    tx_fault_count_q;
  // Receive count saturates; a good frame from passive drops it back
  assign rx_cnt_d = recover_go ? CNT_RESET : // RL22
                    wr_rx_cnt ? i_reg_wdata : // RL7
                    o_line_off_flag ? rx_fault_count_q :
                    (i_rx_err || i_rx_err_major) ?
                      (rx_sum[8] ? CNT_MAX : rx_sum[7:0]) : // RL21
                    (i_rx_ok && rx_hi) ? RX_PASSIVE_BACK :
                    (i_rx_ok && rx_nz) ? rx_fault_count_q - CNT_ONE :
                    rx_fault_count_q;
  assign off_d = recover_go ? 1'b0 : (o_line_off_flag || tx_over); // RL20

  // Flags come from next counter values so they never lag the count
  wire tx_warn = (tx_cnt_d >= WARN_LO) && (tx_cnt_d <= WARN_HI);
  wire rx_warn = (rx_cnt_d >= WARN_LO) && (rx_cnt_d <= WARN_HI);
  wire tx_pas = (tx_cnt_d >= PASSIVE_LO);
  wire rx_pas = (rx_cnt_d >= PASSIVE_LO);

  // ***************************************************************
  // Message status sources
  // ***************************************************************
  cte_filter_pick u_pick (
    .i_hits(i_filter_hits),
    .o_code(pick_code)
  );

  // Transmitter state: disabled, idle, waiting or on the wire
  always_comb
  begin
    case ({i_tx_allow, i_tx_busy, i_queue_empty})
      3'b110, 3'b111: txst_d = TXST_SEND;
      3'b101: txst_d = TXST_IDLE;
      3'b100: txst_d = TXST_WAIT;
      default: txst_d = TXST_OFF;
    endcase
  end // RL17

  // ***************************************************************
  // Registers
  // ***************************************************************
  // Host-visible configuration and counters
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      timing_q <= TIMING_RESET;
      tx_fault_count_q <= CNT_RESET;
      rx_fault_count_q <= CNT_RESET;
      run_q <= RUN_ZERO;
      o_reg_rdata <= RD_NONE;
    end
    else if (i_ce)
    begin
      if (timing_take)
        timing_q <= i_reg_wdata; // RL18
      tx_fault_count_q <= tx_cnt_d;
      rx_fault_count_q <= rx_cnt_d;
      run_q <= run_d;
      if (i_reg_rd)
        o_reg_rdata <= rd_d;
    end
  end

  // Confinement flags, registered from the next counts
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_warn_flag <= 1'b0;
      o_passive_flag <= 1'b0;
      o_line_off_flag <= 1'b0;
      o_tx_passive_bit <= 1'b0;
      o_rx_passive_bit <= 1'b0;
    end
    else if (i_ce)
    begin
      o_warn_flag <= tx_warn || rx_warn; // RL8
      o_passive_flag <= tx_pas || rx_pas;
      o_tx_passive_bit <= tx_pas; // RL9
      o_rx_passive_bit <= rx_pas; // RL10
      o_line_off_flag <= off_d; // RL11
    end
  end

  // Match and tag fields update on their own events only; tx state every cycle
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_match_index <= MATCH_NONE;
      o_last_tag_bits <= 2'b00;
      o_tx_state <= TXST_OFF;
    end
    else if (i_ce)
    begin
      if (i_rx_valid)
        o_match_index <= pick_code; // RL14
      if (i_tx_done)
        o_last_tag_bits <= i_tx_tag; // RL16
      o_tx_state <= txst_d;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_recover_req;
    i_ce && recover_go;
  endsequence

  sequence s_clean_active;
    (tx_fault_count_q == CNT_RESET) && (rx_fault_count_q == CNT_RESET) &&
    !o_line_off_flag && !o_warn_flag && !o_passive_flag;
  endsequence

  a_txc_host_write: assert property ( // RL6
    i_ce && wr_tx_cnt && !recover_go
    |=> tx_fault_count_q == $past(i_reg_wdata))
    else $error("transmit counter write lost");
  a_rxc_host_write: assert property ( // RL7
    i_ce && wr_rx_cnt && !recover_go
    |=> rx_fault_count_q == $past(i_reg_wdata))
    else $error("receive counter write lost");
  a_warn_range: assert property ( // RL8
    o_warn_flag == ((tx_fault_count_q inside {[WARN_LO:WARN_HI]}) ||
                    (rx_fault_count_q inside {[WARN_LO:WARN_HI]})))
    else $error("warning flag disagrees with counters");
  a_tx_passive: assert property ( // RL9
    o_tx_passive_bit == (tx_fault_count_q >= PASSIVE_LO) &&
    (o_passive_flag == (o_tx_passive_bit || o_rx_passive_bit)))
    else $error("transmit passive indication wrong");
  a_rx_passive: assert property ( // RL10
    o_rx_passive_bit == (rx_fault_count_q >= PASSIVE_LO))
    else $error("receive passive indication wrong");
  // A host write in the same cycle wins, so it is left out here
  a_line_off_entry: assert property ( // RL11
    i_ce && tx_over && !wr_tx_cnt |=> o_line_off_flag &&
    tx_fault_count_q == CNT_MAX)
    else $error("line off not entered on counter overflow");
  a_auto_recover: assert property ( // RL12
    i_ce && o_line_off_flag && i_auto_recover_en && o_sample_pt && i_rx_bit &&
    run_full |=> s_clean_active)
    else $error("automatic recovery failed");
  a_recover_clean: assert property (s_recover_req |=> s_clean_active) // RL22
    else $error("recovery left stale fault state");
  a_no_self_clear: assert property ( // RL20
    i_ce && o_line_off_flag && !i_auto_recover_en && !i_host_recover
    |=> o_line_off_flag)
    else $error("line off cleared without recovery");
  a_match_code: assert property ( // RL14
    i_ce && i_rx_valid |=> o_match_index == $past(pick_code))
    else $error("match index not captured");
  a_match_none: assert property ( // RL14
    i_ce && i_rx_valid && (i_filter_hits == 8'h00)
    |=> o_match_index == MATCH_NONE)
    else $error("match index set with no filter hit");
  a_match_lowest: assert property ( // RL15
    (i_filter_hits != 8'h00) |-> pick_code[3] &&
    i_filter_hits[pick_code[2:0]] &&
    ((i_filter_hits & ((8'h01 << pick_code[2:0]) - 8'h01)) == 8'h00))
    else $error("match index not lowest filter");
  a_tag_capture: assert property ( // RL16
    i_ce && i_tx_done |=> o_last_tag_bits == $past(i_tx_tag))
    else $error("last tag not captured");
  a_tx_state_off: assert property ( // RL17
    i_ce && !i_tx_allow |=> o_tx_state == TXST_OFF)
    else $error("transmitter state not off");
  a_timing_lock: assert property ( // RL18
    i_ce && wr_timing && !i_init_mode |=> $stable(timing_q))
    else $error("timing register written outside init");

endmodule

// ===== hdl/cte_filter_pick.sv
`timescale 1ns/10ps
module cte_filter_pick
  import cte_pkg::*;
(
  input wire logic [cte_pkg::NUM_FILTERS-1:0] i_hits,
  output logic [3:0] o_code
);

  // ***************************************************************
  // Lowest matching filter wins
  // ***************************************************************
  logic [NUM_FILTERS:0] seen;
  logic [2:0] acc [0:NUM_FILTERS];

  assign seen[0] = 1'b0;
  assign acc[0] = 3'h0;

  // Scan in rising order; later hits are masked once one is seen
  for (genvar i = 0; i < NUM_FILTERS; i++)
  begin : g_scan
    wire first = i_hits[i] & ~seen[i]; // RL15
    assign seen[i+1] = seen[i] | i_hits[i];
    assign acc[i+1] = acc[i] | (first ? 3'(i) : 3'h0);
  end

  // Top bit marks a hit, low three bits carry its index
  assign o_code = seen[NUM_FILTERS] ? {1'b1, acc[NUM_FILTERS]} :
                  MATCH_NONE; // RL14

endmodule

// ===== hdl/cte_pkg.sv
package cte_pkg;

  // ***************************************************************
  // Register op-codes, as seen by the serial command decoder
  // ***************************************************************
  localparam logic [7:0] OP_WR_TIMING = 8'h1A;
  localparam logic [7:0] OP_RD_TIMING = 8'hD8;
  localparam logic [7:0] OP_WR_TXCNT = 8'h26;
  localparam logic [7:0] OP_RD_TXCNT = 8'hEC;
  localparam logic [7:0] OP_WR_RXCNT = 8'h24;
  localparam logic [7:0] OP_RD_RXCNT = 8'hEA;
  localparam logic [7:0] OP_RD_MSG = 8'hDA;
  localparam logic [7:0] OP_RD_ERR = 8'hDC;

  // ***************************************************************
  // Reset values and field positions
  // ***************************************************************
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] TIMING_RESET = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam int TM_SAMP_BIT = 7;
  localparam int TM_SEG2_HI = 6;
  localparam int TM_SEG2_LO = 4;
  localparam int TM_SEG1_HI = 3;
  localparam int TM_SEG1_LO = 0;
  localparam int ERR_OFF_BIT = 7;
  localparam int ERR_TXP_BIT = 6;
  localparam int ERR_RXP_BIT = 5;
  localparam logic [4:0] ERR_LOW_ZERO = 5'h00;

  // ***************************************************************
  // Fault confinement figures
  // ***************************************************************
  localparam logic [7:0] WARN_LO = 8'h60;
  localparam logic [7:0] WARN_HI = 8'h7F;
  localparam logic [7:0] PASSIVE_LO = 8'h80;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [8:0] TX_ERR_INC = 9'h008;
  localparam logic [8:0] RX_MAJOR_INC = 9'h008;
  localparam logic [8:0] RX_ERR_INC = 9'h001;
  localparam logic [7:0] RX_PASSIVE_BACK = 8'h78;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam int RECOV_RUNS = 128;
  localparam int RECOV_BITS = 11;
  localparam logic [10:0] RECOV_LAST = 11'(RECOV_RUNS * RECOV_BITS - 1);
  localparam logic [10:0] RUN_ONE = 11'h001;
  localparam logic [10:0] RUN_ZERO = 11'h000;

  // ***************************************************************
  // Bit timing and filters
  // ***************************************************************
  localparam logic [4:0] TQ_ONE = 5'h01;
  localparam logic [4:0] TQ_ZERO = 5'h00;
  localparam int NUM_FILTERS = 8;
  localparam logic [3:0] MATCH_NONE = 4'h0;

  // Transmitter state field codes
  typedef enum logic [1:0] {
    TXST_OFF = 2'b00,
    TXST_IDLE = 2'b01,
    TXST_WAIT = 2'b10,
    TXST_SEND = 2'b11
  } cte_txst_e;

endpackage

// ===== verification/cte_bus_node.sv
`timescale 1ns/10ps
// ***************************************************************
// Far-side node on the shared bus
// ***************************************************************
module cte_bus_node
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_bit_end,
  input wire logic i_dominant,
  output logic o_rx_bit
);
  // Level moves only at bit boundaries, as a real node drives it; the
  // idle bus is pulled recessive, so reset leaves it at 1
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rx_bit <= 1'b1;
    else if (i_bit_end)
      o_rx_bit <= #1 !i_dominant;
  end
endmodule

// ===== verification/cte_err_core_tb.sv
`timescale 1ns/10ps
module cte_err_core_tb;
  import cte_pkg::*;
  // ***************************************************************
  // Stimulus and observed signals
  // ***************************************************************
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_ce = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_op = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_init_mode = 1'b0;
  logic i_auto_recover_en = 1'b0;
  logic i_host_recover = 1'b0;
  logic i_tq_tick = 1'b0;
  logic [4:0] evt = 5'h00; // tx_err, tx_ok, rx_err, rx_major, rx_ok
  logic i_rx_valid = 1'b0;
  logic [7:0] i_filter_hits = 8'h00;
  logic i_tx_done = 1'b0;
  logic [1:0] i_tx_tag = 2'h0;
  logic i_tx_allow = 1'b0;
  logic i_queue_empty = 1'b1;
  logic i_tx_busy = 1'b0;
  logic bus_dom = 1'b0;
  logic rx_bit;
  logic [7:0] rdata;
  logic warn, pas, off, txp, rxp, samp, bend, tbad;
  logic [3:0] midx;
  logic [1:0] tag;
  cte_txst_e txst;
  int fails = 0;
  int n_checks = 0;

  // Free-running 40 MHz clock
  always #12.5 i_clk = ~i_clk;

  cte_err_core i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_op(i_reg_op),
    .i_reg_wdata(i_reg_wdata), .i_init_mode(i_init_mode),
    .i_auto_recover_en(i_auto_recover_en), .i_host_recover(i_host_recover),
    .i_tq_tick(i_tq_tick), .i_rx_bit(rx_bit), .i_tx_err(evt[4]),
    .i_tx_ok(evt[3]), .i_rx_err(evt[2]), .i_rx_err_major(evt[1]),
    .i_rx_ok(evt[0]), .i_rx_valid(i_rx_valid),
    .i_filter_hits(i_filter_hits), .i_tx_done(i_tx_done),
    .i_tx_tag(i_tx_tag), .i_tx_allow(i_tx_allow),
    .i_queue_empty(i_queue_empty), .i_tx_busy(i_tx_busy),
    .o_reg_rdata(rdata), .o_warn_flag(warn), .o_passive_flag(pas),
    .o_line_off_flag(off), .o_tx_passive_bit(txp), .o_rx_passive_bit(rxp),
    .o_sample_pt(samp), .o_bit_end(bend), .o_timing_bad(tbad),
    .o_match_index(midx), .o_last_tag_bits(tag), .o_tx_state(txst));

  cte_bus_node i_bus_node (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_bit_end(bend), .i_dominant(bus_dom), .o_rx_bit(rx_bit));

  // ***************************************************************
  // Access tasks; all stimulus moves 1 ns after the rising edge
  // ***************************************************************
  task automatic step(input int n = 1);
    repeat (n)
    begin
      @(posedge i_clk);
      #1;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobes drop and one edge passes, so calls may follow back to back
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    i_reg_wr = 1'b1;
    i_reg_op = op;
    i_reg_wdata = d;
    step();
    i_reg_wr = 1'b0;
    step();
  endtask

  task automatic rdc(input string what, input logic [7:0] op,
                     input logic [7:0] exp);
    i_reg_rd = 1'b1;
    i_reg_op = op;
    step();
    i_reg_rd = 1'b0;
    chk(what, exp, rdata);
    step();
  endtask

  task automatic ev(input logic [4:0] e);
    evt = e;
    step();
    evt = 5'h00;
    step();
  endtask

  // Flags packed as warn, passive, line off, tx passive, rx passive
  task automatic flg(input logic [4:0] exp);
    chk("flags", {3'h0, exp}, {3'h0, warn, pas, off, txp, rxp});
  endtask

  // One counter step: optional write, optional event, readback, flags
  task automatic tcase(input logic [7:0] wop, input logic [7:0] wv,
    input logic [4:0] e, input logic [7:0] rop, input logic [7:0] exp,
    input logic [4:0] fl);
    if (wop != 8'h00)
      wr(wop, wv);
    if (e != 5'h00)
      ev(e);
    rdc("count", rop, exp);
    flg(fl);
  endtask

  // Bounded wait for bit end (sel 1) or sample point (sel 0)
  task automatic wp(input bit sel, output int n);
    n = 1;
    step();
    while ((sel ? bend : samp) !== 1'b1 && n < 100)
    begin
      step();
      n++;
    end
    if (n >= 100)
    begin
      fails++;
      stop_test();
    end
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    int n;
    int c;
    repeat (3) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    step();
    rdc("tx count", OP_RD_TXCNT, CNT_RESET);
    rdc("rx count", OP_RD_RXCNT, CNT_RESET);
    rdc("msg status", OP_RD_MSG, 8'h00);
    rdc("unmapped", 8'h00, RD_NONE);
    rdc("timing", OP_RD_TIMING, TIMING_RESET);
    wr(OP_WR_TIMING, 8'h14);
    rdc("timing", OP_RD_TIMING, 8'h00);
    i_init_mode = 1'b1;
    // Each zero code starts from a valid setting so the flag must move
    wr(OP_WR_TIMING, 8'h14);
    chk("timing bad", 8'h00, tbad);
    wr(OP_WR_TIMING, 8'h04);
    chk("timing bad", 8'h01, tbad);
    wr(OP_WR_TIMING, 8'h14);
    wr(OP_WR_TIMING, 8'h10);
    chk("timing bad", 8'h01, tbad);
    // Eight quanta, sample at 75%, segment one above phase segment two
    wr(OP_WR_TIMING, 8'h14);
    rdc("timing", OP_RD_TIMING, 8'h14);
    chk("timing bad", 8'h00, tbad);
    i_init_mode = 1'b0;
    i_tq_tick = 1'b1;
    wp(1'b1, n);
    wp(1'b0, n);
    chk("to sample", 8'h06, n[7:0]);
    wp(1'b1, n);
    chk("phase two", 8'h02, n[7:0]);
    // Threshold walk on both counters
    tcase(OP_WR_TXCNT, 8'h5F, 5'h00, OP_RD_TXCNT, 8'h5F, 5'h00);
    tcase(8'h00, 8'h00, 5'h10, OP_RD_TXCNT, 8'h67, 5'h10);
    tcase(OP_WR_TXCNT, 8'h7F, 5'h10, OP_RD_TXCNT, 8'h87, 5'h0A);
    tcase(OP_WR_TXCNT, 8'h80, 5'h08, OP_RD_TXCNT, 8'h7F, 5'h10);
    tcase(OP_WR_TXCNT, 8'h00, 5'h00, OP_RD_TXCNT, 8'h00, 5'h00);
    // Clock enable low: a transmit error must leave the count alone
    i_ce = 1'b0;
    ev(5'h10);
    i_ce = 1'b1;
    rdc("tx held", OP_RD_TXCNT, 8'h00);
    tcase(OP_WR_RXCNT, 8'h60, 5'h00, OP_RD_RXCNT, 8'h60, 5'h10);
    tcase(OP_WR_RXCNT, 8'h7F, 5'h04, OP_RD_RXCNT, 8'h80, 5'h09);
    tcase(8'h00, 8'h00, 5'h01, OP_RD_RXCNT, 8'h78, 5'h10);
    tcase(8'h00, 8'h00, 5'h02, OP_RD_RXCNT, 8'h80, 5'h09);
    tcase(OP_WR_RXCNT, 8'h00, 5'h01, OP_RD_RXCNT, 8'h00, 5'h00);
    // Line off, then host-driven recovery with auto recovery off
    wr(OP_WR_RXCNT, 8'h30);
    tcase(OP_WR_TXCNT, 8'hF8, 5'h10, OP_RD_ERR, 8'hC0, 5'h0E);
    ev(5'h10);
    rdc("tx frozen", OP_RD_TXCNT, 8'hFF);
    step(40);
    chk("line off", 8'h01, off);
    i_host_recover = 1'b1;
    step();
    i_host_recover = 1'b0;
    step();
    rdc("rx count", OP_RD_RXCNT, 8'h00);
    tcase(8'h00, 8'h00, 5'h00, OP_RD_TXCNT, 8'h00, 5'h00);
    // Auto recovery after one dominant bit then 128 x 11 recessive bits
    wr(OP_WR_RXCNT, 8'h30);
    tcase(OP_WR_TXCNT, 8'hF8, 5'h10, OP_RD_ERR, 8'hC0, 5'h0E);
    i_auto_recover_en = 1'b1;
    bus_dom = 1'b1;
    n = 0;
    while (!(samp === 1'b1 && rx_bit === 1'b0) && n < 100)
    begin
      step();
      n++;
    end
    if (n >= 100)
    begin
      fails++;
      stop_test();
    end
    bus_dom = 1'b0;
    c = 0;
    while (c < RECOV_RUNS * RECOV_BITS && n < 20000)
    begin
      step();
      n++;
      if (samp === 1'b1 && rx_bit === 1'b1)
        c++;
    end
    if (n >= 20000)
    begin
      fails++;
      stop_test();
    end
    chk("line off", 8'h01, off);
    step();
    chk("line off", 8'h00, off);
    rdc("err", OP_RD_ERR, 8'h00);
    rdc("rx count", OP_RD_RXCNT, 8'h00);
    tcase(8'h00, 8'h00, 5'h00, OP_RD_TXCNT, 8'h00, 5'h00);
    // Filter priority: every index with all higher filters also hitting
    for (int i = 0; i < NUM_FILTERS; i++)
    begin
      i_filter_hits = 8'hFF << i;
      i_rx_valid = 1'b1;
      step();
      i_rx_valid = 1'b0;
      step();
      chk("match", {5'h01, i[2:0]}, {4'h0, midx});
    end
    i_filter_hits = 8'h00;
    i_rx_valid = 1'b1;
    step();
    i_rx_valid = 1'b0;
    i_tx_tag = 2'h2;
    i_tx_done = 1'b1;
    step();
    i_tx_done = 1'b0;
    i_tx_tag = 2'h1;
    // Each transmitter state through the status register
    for (int k = 0; k < 4; k++)
    begin
      i_tx_allow = (k > 0);
      i_queue_empty = (k == 1);
      i_tx_busy = (k == 3);
      step(2);
      rdc("msg status", OP_RD_MSG, {6'h02, k[1:0]});
    end
    stop_test();
  end
endmodule
